//--- hdl/pcs_100m_config_register.sv
/*
  Coding sublayer configuration and status register bank with the
  small amount of logic its bits steer: forced signal detect, forced
  link, and the descrambler loss-of-sync timer.
  Assumes an APB master on sys_clk and raw line indications from
  outside the clock domain; idle detect comes from same-clock logic.
*/
`timescale 1ns/100ps

// Overview of operation
// - Bits 15 to 13 of the configuration register read zero, writes lost.
// - Bit 10 set puts the transmitter into true quiet mode.
// - Bit 9 set forces signal detect active whatever the line does.
// - Bit 8 picks the enhanced (one) or reduced (zero) detect algorithm.
// - Bit 7 selects a 2 ms (one) or 722 us (zero) descrambler timeout.
// - With the long timeout, sync survives frames over nine kilobytes.
// - Bit 5 set reports a good 100 Mb/s link whatever the line state.
// - Bit 2 set bypasses the line encode and decode stage.
// - The configuration register sits at register index 0x16.
module pcs_100m_config_register
  import pcs_pkg::*;
#(
  parameter int SHORT_CYC = DESC_SHORT_CYC,
  parameter int LONG_CYC  = DESC_LONG_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // line indications
  input  wire logic        sdLineRaw,
  input  wire logic        linkLineRaw,
  input  wire logic        descIdleSeen,
  // steering outputs
  output pcs_cfg_s         cfg,
  output logic             signalDetect,
  output logic             link100Good,
  output logic             descSyncLost
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  function automatic logic isAddr(input logic [31:0] a,
                                  input logic [9:0]  r);
    isAddr = (a[31:10] == 22'h000000) && (a[9:0] == r);
  endfunction

  logic hitCfg;
  logic hitSts;
  logic setup;
  logic access;
  logic cfgWrite;

  assign hitCfg   = isAddr(paddr, CFG_ADDR);
  assign hitSts   = isAddr(paddr, STS_ADDR);
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign cfgWrite = access && pwrite && hitCfg;
  assign pready   = 1'b1;
  assign pslverr  = access && !(hitCfg || hitSts);

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  pcs_cfg_s cfg_q;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cfg_q.trueQuiet  <= CFG_RESET[TQ_BIT];
      cfg_q.sdForce    <= CFG_RESET[SD_FORCE_BIT];
      cfg_q.sdAlgo     <= CFG_RESET[SD_ALGO_BIT];
      cfg_q.descLong   <= CFG_RESET[DESC_BIT];
      cfg_q.forceGood  <= CFG_RESET[FORCE_OK_BIT];
      cfg_q.nrziBypass <= CFG_RESET[NRZI_BIT];
    end else if (cfgWrite) begin
      cfg_q.trueQuiet  <= pwdata[TQ_BIT];
      cfg_q.sdForce    <= pwdata[SD_FORCE_BIT];
      cfg_q.sdAlgo     <= pwdata[SD_ALGO_BIT];
      cfg_q.descLong   <= pwdata[DESC_BIT];
      cfg_q.forceGood  <= pwdata[FORCE_OK_BIT];
      cfg_q.nrziBypass <= pwdata[NRZI_BIT];
    end
  end

  assign cfg = cfg_q;

  // ---------------------------------------------------------------
  // line input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sdSync_q;
  logic [2:0] linkSync_q;
  logic       sdLine_q;
  logic       linkLine_q;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sdSync_q   <= 3'h0;
      linkSync_q <= 3'h0;
    end else begin
      sdSync_q   <= {sdSync_q[1:0], sdLineRaw};
      linkSync_q <= {linkSync_q[1:0], linkLineRaw};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sdLine_q   <= 1'b0;
      linkLine_q <= 1'b0;
    end else begin
      if (sdSync_q[1] == sdSync_q[2]) begin
        sdLine_q <= sdSync_q[2];
      end
      if (linkSync_q[1] == linkSync_q[2]) begin
        linkLine_q <= linkSync_q[2];
      end
    end
  end

  assign signalDetect = cfg_q.sdForce || sdLine_q;
  assign link100Good  = cfg_q.forceGood || linkLine_q;

  // ---------------------------------------------------------------
  // descrambler loss-of-sync timer
  // ---------------------------------------------------------------
  logic [TIMER_W-1:0] timeoutLimit;
  logic [TIMER_W-1:0] timer_q;
  logic               lost_q;

  assign timeoutLimit = cfg_q.descLong ? TIMER_W'(LONG_CYC)
                                       : TIMER_W'(SHORT_CYC);

  // idle restarts the count; a long frame only runs the count
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      timer_q <= '0;
      lost_q  <= 1'b0;
    end else if (descIdleSeen) begin
      timer_q <= '0;
      lost_q  <= 1'b0;
    end else if (!lost_q) begin
      if (timer_q >= timeoutLimit - TIMER_W'(1)) begin
        lost_q  <= 1'b1;
        timer_q <= '0;
      end else begin
        timer_q <= timer_q + TIMER_W'(1);
      end
    end
  end

  assign descSyncLost = lost_q;

  // ---------------------------------------------------------------
  // read data, captured in the setup cycle
  // ---------------------------------------------------------------
  logic [31:0] cfgWord;
  logic [31:0] stsWord;

  always_comb begin
    cfgWord               = 32'h00000000;
    cfgWord[TQ_BIT]       = cfg_q.trueQuiet;
    cfgWord[SD_FORCE_BIT] = cfg_q.sdForce;
    cfgWord[SD_ALGO_BIT]  = cfg_q.sdAlgo;
    cfgWord[DESC_BIT]     = cfg_q.descLong;
    cfgWord[FORCE_OK_BIT] = cfg_q.forceGood;
    cfgWord[NRZI_BIT]     = cfg_q.nrziBypass;
    stsWord               = 32'h00000000;
    stsWord[STS_LINK_BIT] = link100Good;
    stsWord[STS_SD_BIT]   = signalDetect;
    stsWord[STS_LOST_BIT] = lost_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= hitCfg ? cfgWord : (hitSts ? stsWord : 32'h00000000);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_reserved_zero;
    @(posedge sys_clk) disable iff (!resetn)
    access && !pwrite && hitCfg |-> prdata[31:13] == 19'h00000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_quiet_write;
    @(posedge sys_clk) disable iff (!resetn)
    cfgWrite |=> cfg.trueQuiet == $past(pwdata[TQ_BIT]);
  endproperty
  a_quiet_write: assert property (p_quiet_write)
    else $error("true quiet bit not written");

  property p_sd_force;
    @(posedge sys_clk) disable iff (!resetn)
    cfg.sdForce |-> signalDetect;
  endproperty
  a_sd_force: assert property (p_sd_force)
    else $error("forced signal detect not active");

  property p_algo_write;
    @(posedge sys_clk) disable iff (!resetn)
    cfgWrite ##1 !cfgWrite |-> cfg.sdAlgo == $past(pwdata[SD_ALGO_BIT]);
  endproperty
  a_algo_write: assert property (p_algo_write)
    else $error("algorithm select not held");

  // independent age of the running count, for the timeout check
  logic [TIMER_W:0] idleAge_q;
  logic             selSteady_q;

  // a select change mid-count leaves the age meaningless
  always_ff @(posedge sys_clk) begin
    if (!resetn || descIdleSeen) begin
      idleAge_q   <= '0;
      selSteady_q <= 1'b1;
    end else begin
      if (!lost_q) begin
        idleAge_q <= idleAge_q + (TIMER_W+1)'(1);
      end
      if (cfgWrite && (pwdata[DESC_BIT] != cfg_q.descLong)) begin
        selSteady_q <= 1'b0;
      end
    end
  end

  property p_timeout_sel;
    @(posedge sys_clk) disable iff (!resetn)
    $rose(descSyncLost) && selSteady_q |->
      idleAge_q == (cfg.descLong ? (TIMER_W+1)'(LONG_CYC)
                                 : (TIMER_W+1)'(SHORT_CYC));
  endproperty
  a_timeout_sel: assert property (p_timeout_sel)
    else $error("descrambler timeout wrong");

  property p_sync_hold;
    @(posedge sys_clk) disable iff (!resetn)
    $rose(descSyncLost) |->
      $past(timer_q) == $past(timeoutLimit) - TIMER_W'(1)
      && !$past(descIdleSeen);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("sync lost before the timeout");

  property p_force_link;
    @(posedge sys_clk) disable iff (!resetn)
    cfg.forceGood |-> link100Good;
  endproperty
  a_force_link: assert property (p_force_link)
    else $error("forced link not reported good");

  property p_nrzi_write;
    @(posedge sys_clk) disable iff (!resetn)
    cfgWrite |=> cfg.nrziBypass == $past(pwdata[NRZI_BIT]);
  endproperty
  a_nrzi_write: assert property (p_nrzi_write)
    else $error("bypass bit not written");

  property p_decode;
    @(posedge sys_clk) disable iff (!resetn)
    access |-> pslverr == !(paddr == {22'h0, CFG_ADDR} || hitSts);
  endproperty
  a_decode: assert property (p_decode)
    else $error("register decode wrong");

  property p_reset_value;
    @(posedge sys_clk) disable iff (!resetn)
    $rose(resetn) |-> cfg == pcs_cfg_s'(6'b001000);
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("reset value wrong");

endmodule

//--- hdl/pcs_pkg.sv
/*
  Package for the 100 Mb/s coding sublayer configuration register:
  register indices, field positions, reset values, timing figures
  and the configuration carrier struct.
  Assumes a 100 MHz management clock and a 32-bit APB register bus.
*/
package pcs_pkg;

  // ---------------------------------------------------------------
  // register map (index; byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0]  CFG_IDX      = 8'h16;
  localparam logic [7:0]  STS_IDX      = 8'h20;
  localparam logic [9:0]  CFG_ADDR     = {CFG_IDX, 2'b00};
  localparam logic [9:0]  STS_ADDR     = {STS_IDX, 2'b00};

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          TQ_BIT       = 10;
  localparam int          SD_FORCE_BIT = 9;
  localparam int          SD_ALGO_BIT  = 8;
  localparam int          DESC_BIT     = 7;
  localparam int          FORCE_OK_BIT = 5;
  localparam int          NRZI_BIT     = 2;
  localparam int          STS_LINK_BIT = 0;
  localparam int          STS_SD_BIT   = 1;
  localparam int          STS_LOST_BIT = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_RESET    = 16'h0100;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          DESC_SHORT_NS   = 722000;
  localparam int          DESC_LONG_NS    = 2000000;
  localparam int          DESC_SHORT_CYC  = DESC_SHORT_NS / CLK_PERIOD_NS;
  localparam int          DESC_LONG_CYC   = DESC_LONG_NS / CLK_PERIOD_NS;
  localparam int          TIMER_W         = 18;

  typedef struct packed {
    logic trueQuiet;
    logic sdForce;
    logic sdAlgo;
    logic descLong;
    logic forceGood;
    logic nrziBypass;
  } pcs_cfg_s;

endpackage

//--- verification/pcs_100m_config_register_test.sv
/*
  Self-checking bench for the coding sublayer configuration register.
  Assumes pcs_pkg and a zero-wait APB slave with shortened timer counts.
*/
`timescale 1ns/100ps
module pcs_100m_config_register_test
  import pcs_pkg::*;
;
  localparam int SHORT = 20;
  localparam int LONG  = 50;
  logic        sys_clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic        pready;
  logic        pslverr;
  logic        rerr;
  logic        sdLineRaw;
  logic        linkLineRaw;
  logic        descIdleSeen;
  pcs_cfg_s    cfg;
  logic        signalDetect;
  logic        link100Good;
  logic        descSyncLost;
  int          nFail;
  int          checked;
  int          fb [6];

  pcs_100m_config_register #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sdLineRaw(sdLineRaw),
    .linkLineRaw(linkLineRaw), .descIdleSeen(descIdleSeen), .cfg(cfg),
    .signalDetect(signalDetect), .link100Good(link100Good),
    .descSyncLost(descSyncLost));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      nFail++;
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    k = 0;
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
      k++;
    end
    chk("pready waits", 32'h0, k);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrapUp;
    $display("checks %0d failures %0d", checked, nFail);
    if (nFail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, {22'h0, CFG_ADDR}, 32'h0);
    chk("cfg read after reset", 32'h0000_0100, rdat);
    chk("cfg port after reset", 32'h0000_0008, {26'h0, cfg});
  endtask

  task automatic t_reserved;
    apb(1'b1, {22'h0, CFG_ADDR}, 32'hFFFF_E7A4);
    apb(1'b0, {22'h0, CFG_ADDR}, 32'h0);
    chk("cfg all ones", 32'h0000_07A4, rdat);
    chk("cfg port all ones", 32'h0000_003F, {26'h0, cfg});
  endtask

  task automatic t_fields;
    fb = '{TQ_BIT, SD_FORCE_BIT, SD_ALGO_BIT, DESC_BIT, FORCE_OK_BIT,
           NRZI_BIT};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, {22'h0, CFG_ADDR}, 32'h1 << fb[i]);
      @(posedge sys_clk);
      chk("port", 32'h20 >> i, {26'h0, cfg});
      apb(1'b0, {22'h0, CFG_ADDR}, 32'h0);
      chk("read", 32'h1 << fb[i], rdat);
    end
  endtask

  task automatic t_force;
    apb(1'b1, {22'h0, CFG_ADDR}, 32'h0000_0220);
    repeat (2) @(posedge sys_clk);
    chk("forced detect", 32'h1, {31'h0, signalDetect});
    chk("forced link", 32'h1, {31'h0, link100Good});
    apb(1'b1, {22'h0, CFG_ADDR}, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("unforced detect", 32'h0, {31'h0, signalDetect});
    chk("unforced link", 32'h0, {31'h0, link100Good});
    sdLineRaw   <= 1'b1;
    linkLineRaw <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("line detect", 32'h1, {31'h0, signalDetect});
    chk("line link", 32'h1, {31'h0, link100Good});
    sdLineRaw   <= 1'b0;
    linkLineRaw <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic t_timer(input logic longSel, input int lim);
    apb(1'b1, {22'h0, CFG_ADDR}, {24'h0, longSel, 7'h0});
    @(posedge sys_clk);
    descIdleSeen <= 1'b1;
    @(posedge sys_clk);
    descIdleSeen <= 1'b0;
    repeat (lim - 1) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("sync held", 32'h0, {31'h0, descSyncLost});
    @(negedge sys_clk);
    chk("sync lost", 32'h1, {31'h0, descSyncLost});
    apb(1'b0, {22'h0, STS_ADDR}, 32'h0);
    chk("status lost", 32'h0000_0004, rdat);
  endtask

  task automatic t_unmapped;
    apb(1'b1, 32'h0000_0400, 32'h0000_FFFF);
    chk("unmapped write err", 32'h1, {31'h0, rerr});
    apb(1'b0, 32'h0000_0400, 32'h0);
    chk("unmapped read err", 32'h1, {31'h0, rerr});
    chk("unmapped read data", 32'h0, rdat);
    apb(1'b1, 32'h0000_0016, 32'h0000_0400);
    chk("printed offset err", 32'h1, {31'h0, rerr});
    apb(1'b1, {22'h0, STS_ADDR}, 32'h0000_FFFF);
    chk("status write err", 32'h0, {31'h0, rerr});
    apb(1'b0, {22'h0, CFG_ADDR}, 32'h0);
    chk("cfg untouched", 32'h0000_0080, rdat);
  endtask

  task automatic t_midreset;
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset;
    chk("sync lost after reset", 32'h0, {31'h0, descSyncLost});
  endtask

  // ---------------------------------------------------------------
  // clock, main sequence, watchdog
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    sdLineRaw = 1'b0;
    linkLineRaw = 1'b0;
    descIdleSeen = 1'b0;
    nFail = 0;
    checked = 0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset;
    t_reserved;
    t_fields;
    t_force;
    t_timer(1'b0, SHORT);
    t_timer(1'b1, LONG);
    t_unmapped;
    t_midreset;
    wrapUp;
  end

  initial begin
    repeat (3000) @(posedge sys_clk);
    nFail++;
    wrapUp;
  end
endmodule
